//--- sfa_flash_top.sv
// Serial flash array: command core, page array, page buffers, erase engine.
// Assumes a mode 3 master on the link pins; control inputs are synchronous.
`include "sfa_map.svh"
`default_nettype none
module sfa_flash_top
  import sfa_pkg::*;
#(
  parameter int PAGE_BYTES = `SFA_PAGE_BYTES,
  parameter int NUM_PAGES = `SFA_NUM_PAGES,
  parameter int SECTOR_PAGES = `SFA_SECTOR_PAGES,
  parameter int NUM_BUF = 1,
  parameter bit BIG_VARIANT = 1'b0,
  parameter logic [7:0] MFR_ID = 8'h5a, // Arbitrary value
  parameter logic [7:0] DEV_ID_SMALL = 8'h3c, // Arbitrary value
  parameter logic [7:0] DEV_ID_BIG = 8'h3d, // Arbitrary value
  parameter logic [7:0] ID_BYTE3 = 8'h00, // Arbitrary value
  parameter logic [7:0] EXT_BYTE = 8'h01 // Arbitrary value
) (
  // System
  input wire logic clock_i,
  input wire logic nrst_i,
  // Link pins
  input wire logic spi_clk_i,
  input wire logic spi_csn_i,
  input wire logic spi_mosi_i,
  output logic spi_miso_o,
  // Array controls
  input wire logic pow2_mode_i,
  input wire logic [NUM_PAGES/SECTOR_PAGES:0] sector_protect_i,
  input wire logic [NUM_PAGES/SECTOR_PAGES:0] sector_lock_i,
  // Status
  output logic busy_o
);
  localparam int BYTE_W = $clog2(PAGE_BYTES);
  localparam int PAGE_W = $clog2(NUM_PAGES);
  localparam int MEM_N = NUM_PAGES * PAGE_BYTES;
  localparam int MEM_AW = $clog2(MEM_N);
  localparam int BUF_N = NUM_BUF * PAGE_BYTES;
  localparam int BUF_AW = $clog2(BUF_N + 1);
  localparam logic [BYTE_W-1:0] PLAST = BYTE_W'(PAGE_BYTES - 1);
  localparam logic [BYTE_W-1:0] P2LAST = BYTE_W'((2 ** (BYTE_W - 1)) - 1);
  localparam logic [PAGE_W-1:0] LASTPG = PAGE_W'(NUM_PAGES - 1);
  localparam logic [PAGE_W-1:0] SECMSK = PAGE_W'(SECTOR_PAGES - 1);
  localparam logic [PAGE_W-1:0] SUB0A = PAGE_W'(`SFA_SUB0A_PAGES);
  localparam logic [PAGE_W-1:0] BLKMSK = PAGE_W'(`SFA_BLOCK_PAGES - 1);

  typedef struct packed {
    sfa_state_t st;
    logic [7:0] cmd;
    logic [`SFA_ADDR_BITS-1:0] addr;
    logic [1:0] acnt;
    logic armed;
    logic [2:0] seq;
    logic bsel;
    logic [PAGE_W-1:0] page;
    logic [BYTE_W-1:0] byt;
    logic [7:0] tx;
    sfa_op_t op;
    logic keep;
    logic [PAGE_W-1:0] e_page;
    logic [PAGE_W-1:0] e_last;
    logic [BYTE_W-1:0] e_byte;
  } sfa_core_st_t;

  sfa_core_st_t q, d;
  sfa_byte_if bif ();
  logic [7:0] mem_q [MEM_N];
  logic [7:0] buf_q [BUF_N];
  logic mem_we, buf_we;
  logic [MEM_AW-1:0] mem_wa;
  logic [BUF_AW-1:0] buf_wa;
  logic [7:0] mem_wd, buf_wd;

  sfa_spi_shift u_shift (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .spi_clk_i(spi_clk_i),
    .spi_csn_i(spi_csn_i),
    .spi_mosi_i(spi_mosi_i),
    .spi_miso_o(spi_miso_o),
    .bif(bif)
  );

  // ==========================================================
  // Address helpers
  function automatic logic [MEM_AW-1:0] midx(input logic [PAGE_W-1:0] pg,
                                             input logic [BYTE_W-1:0] by);
    midx = MEM_AW'(pg) * MEM_AW'(PAGE_BYTES) + MEM_AW'(by);
  endfunction

  function automatic logic [BUF_AW-1:0] bidx(input logic bs, input logic [BYTE_W-1:0] by);
    bidx = BUF_AW'(bs) * BUF_AW'(PAGE_BYTES) + BUF_AW'(by);
  endfunction

  // Each protection unit: 0 is the lower part of sector zero, 1 its upper part
  function automatic int unsigned prot_unit(input logic [PAGE_W-1:0] pg);
    if (pg < SUB0A) prot_unit = 0;
    else prot_unit = int'(pg / PAGE_W'(SECTOR_PAGES)) + 1;
  endfunction

  logic [BYTE_W-1:0] plast;
  logic [`SFA_ADDR_BITS-1:0] naddr;
  logic [PAGE_W-1:0] npage;
  logic [BYTE_W-1:0] nbyte;
  logic [7:0] stat0, rx;
  logic two_buf, busy;

  assign plast = pow2_mode_i ? P2LAST : PLAST;
  assign two_buf = (NUM_BUF > 1);
  assign busy = (q.op != OP_NONE);
  assign rx = bif.rx_byte;
  assign naddr = {q.addr[15:0], rx};
  assign stat0 = {~busy, 1'b0, BIG_VARIANT ? `SFA_DENS_BIG : `SFA_DENS_SMALL,
                  |(sector_protect_i | sector_lock_i), pow2_mode_i};

  // ==========================================================
  // Command sequencer and background engine
  always_comb begin
    d = q;
    nbyte = '0;
    npage = '0;
    mem_we = 1'b0;
    mem_wa = '0;
    mem_wd = `SFA_ERASED;
    buf_we = 1'b0;
    buf_wa = '0;
    buf_wd = 8'h00;
    // Upper bits beyond the array are simply not looked at
    if (pow2_mode_i) begin
      npage = naddr[BYTE_W-1 +: PAGE_W];
      nbyte = {1'b0, naddr[BYTE_W-2:0]};
    end else begin
      npage = naddr[BYTE_W +: PAGE_W];
      nbyte = (naddr[BYTE_W-1:0] > PLAST) ? '0 : naddr[BYTE_W-1:0];
    end
    if (bif.rx_valid) begin
      case (q.st)
        ST_CMD: begin
          d.cmd = rx;
          // Stale data must not leak out during address or ignored bytes
          d.tx = `SFA_ERASED;
          d.seq = 3'h0;
          d.acnt = 2'h0;
          d.armed = 1'b0;
          d.bsel = (rx == `SFA_CMD_BWR2) || (rx == `SFA_CMD_PGM2) ||
                   (rx == `SFA_CMD_PNE2) || (rx == `SFA_CMD_XFR2);
          if (rx == `SFA_CMD_STATUS) begin
            d.st = ST_DATA;
            d.tx = stat0;
          end else if (rx == `SFA_CMD_INFO) begin
            d.st = ST_DATA;
            d.tx = MFR_ID;
          end else if (busy || (d.bsel && !two_buf)) begin
            d.st = ST_IGN;
          end else begin
            case (rx)
              `SFA_CMD_READ, `SFA_CMD_FAST, `SFA_CMD_BWR1, `SFA_CMD_BWR2, `SFA_CMD_PGM1,
              `SFA_CMD_PGM2, `SFA_CMD_PNE1, `SFA_CMD_PNE2, `SFA_CMD_XFR1, `SFA_CMD_XFR2,
              `SFA_CMD_PGER, `SFA_CMD_BLKER, `SFA_CMD_SECER: d.st = ST_ADDR;
              default: d.st = ST_IGN;
            endcase
          end
        end
        ST_ADDR: begin
          d.addr = naddr;
          d.acnt = q.acnt + 2'h1;
          if (q.acnt == 2'h2) begin
            d.page = npage;
            d.byt = nbyte;
            case (q.cmd)
              `SFA_CMD_FAST: d.st = ST_DUMMY;
              `SFA_CMD_READ: begin
                d.st = ST_DATA;
                d.tx = mem_q[midx(npage, nbyte)];
                d.byt = (nbyte == plast) ? '0 : nbyte + 1'b1;
                if (nbyte == plast) d.page = (npage == LASTPG) ? '0 : npage + 1'b1;
              end
              `SFA_CMD_BWR1, `SFA_CMD_BWR2: d.st = ST_DATA;
              default: begin
                d.st = ST_IGN;
                d.armed = 1'b1;
              end
            endcase
          end
        end
        ST_DUMMY, ST_DATA: begin
          d.st = ST_DATA;
          case (q.cmd)
            `SFA_CMD_STATUS: begin
              d.seq = BIG_VARIANT ? {2'h0, ~q.seq[0]} : 3'h0;
              d.tx = (BIG_VARIANT && !q.seq[0]) ? {~busy, 7'h00} : stat0;
            end
            `SFA_CMD_INFO: begin
              d.seq = (q.seq == `SFA_ID_LAST) ? q.seq : q.seq + 3'h1;
              case (q.seq)
                3'h0: d.tx = BIG_VARIANT ? DEV_ID_BIG : DEV_ID_SMALL;
                3'h1: d.tx = ID_BYTE3;
                3'h2: d.tx = {7'h00, BIG_VARIANT};
                3'h3: d.tx = BIG_VARIANT ? EXT_BYTE : `SFA_ERASED;
                default: d.tx = `SFA_ERASED;
              endcase
            end
            `SFA_CMD_BWR1, `SFA_CMD_BWR2: begin
              if (q.st == ST_DATA) begin
                buf_we = 1'b1;
                buf_wa = bidx(q.bsel, q.byt);
                buf_wd = rx;
                d.byt = (q.byt == plast) ? '0 : q.byt + 1'b1;
              end
            end
            default: begin
              // Continuous read walks the whole array, then the first page
              d.tx = mem_q[midx(q.page, q.byt)];
              d.byt = (q.byt == plast) ? '0 : q.byt + 1'b1;
              if (q.byt == plast) d.page = (q.page == LASTPG) ? '0 : q.page + 1'b1;
            end
          endcase
        end
        ST_IGN: d.st = ST_IGN;
        default: d.st = ST_IGN;
      endcase
    end
    // Background engine: one byte a clock, only status and identification are taken while it runs
    if (busy) begin
      case (q.op)
        OP_ERASE: begin
          mem_we = 1'b1;
          mem_wa = midx(q.e_page, q.e_byte);
          mem_wd = `SFA_ERASED;
        end
        OP_PROG: begin
          mem_we = 1'b1;
          mem_wa = midx(q.e_page, q.e_byte);
          mem_wd = buf_q[bidx(q.bsel, q.e_byte)] & (q.keep ? mem_q[mem_wa] : 8'hff);
        end
        OP_XFER: begin
          buf_we = 1'b1;
          buf_wa = bidx(q.bsel, q.e_byte);
          buf_wd = mem_q[midx(q.e_page, q.e_byte)];
        end
        default: d.op = OP_NONE;
      endcase
      d.e_byte = (q.e_byte == PLAST) ? '0 : q.e_byte + 1'b1;
      if (q.e_byte == PLAST) begin
        if (q.e_page == q.e_last) d.op = OP_NONE;
        else d.e_page = q.e_page + 1'b1;
      end
    end
    // Deselect ends the command; array work starts only now
    if (bif.cs_end) begin
      d.st = ST_CMD;
      d.armed = 1'b0;
      if (q.armed && !busy) begin
        d.e_page = q.page;
        d.e_last = q.page;
        d.e_byte = '0;
        d.keep = (q.cmd == `SFA_CMD_PNE1) || (q.cmd == `SFA_CMD_PNE2);
        case (q.cmd)
          `SFA_CMD_PGER: d.op = OP_ERASE;
          `SFA_CMD_BLKER: begin
            d.op = OP_ERASE;
            d.e_page = q.page & ~BLKMSK;
            d.e_last = q.page | BLKMSK;
          end
          `SFA_CMD_SECER: begin
            d.op = OP_ERASE;
            if (q.page < SUB0A) begin
              d.e_page = '0;
              d.e_last = SUB0A - 1'b1;
            end else if (q.page <= SECMSK) begin
              d.e_page = SUB0A;
              d.e_last = SECMSK;
            end else begin
              d.e_page = q.page & ~SECMSK;
              d.e_last = q.page | SECMSK;
            end
          end
          `SFA_CMD_PGM1, `SFA_CMD_PGM2, `SFA_CMD_PNE1, `SFA_CMD_PNE2: d.op = OP_PROG;
          `SFA_CMD_XFR1, `SFA_CMD_XFR2: d.op = OP_XFER;
          default: d.op = OP_NONE;
        endcase
        // Protected or locked units refuse any change, whatever the granularity
        if (d.op != OP_XFER && (sector_protect_i[prot_unit(d.e_page)] ||
            sector_lock_i[prot_unit(d.e_page)])) d.op = OP_NONE;
      end
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q <= '{st: ST_CMD, cmd: 8'h00, addr: '0, acnt: 2'h0, armed: 1'b0, seq: 3'h0,
             bsel: 1'b0, page: '0, byt: '0, tx: 8'hff, op: OP_NONE, keep: 1'b0,
             e_page: '0, e_last: '0, e_byte: '0};
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // Storage; array comes out of reset erased
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < MEM_N; i++) mem_q[i] <= `SFA_ERASED;
    end else if (mem_we) begin
      mem_q[mem_wa] <= mem_wd;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < BUF_N; i++) buf_q[i] <= `SFA_ERASED;
    end else if (buf_we) begin
      buf_q[buf_wa] <= buf_wd;
    end
  end

  assign bif.tx_byte = q.tx;
  assign busy_o = busy;
endmodule // sfa_flash_top
`default_nettype wire

//--- sfa_map.svh
// Constants for the serial flash array block: offsets, sizes, codes, commands.
// Assumes inclusion by bare name from the package and the design modules.
// Behaviour
// - Addressed commands carry a 24-bit address
// - Default page is 264 bytes, largest 528
// - Erase works per page; buffers per byte
// - Block of eight pages erased as one
// - Sector is 256 pages, smallest part 128
// - Sector zero split: eight pages, then rest
// - Protection and lockdown cover whole sector contents
// - Continuous read wraps to first page, no delay
// - Two page buffers; smallest part only one
// - Status density code 0011 or 0101
// - Identification second byte differs per density
// - Power-of-two mode shrinks page; default larger
// - Larger variant behaves identically over first part
// - Serial clocking follows mode 3, master clocks
// - All fields shifted most significant bit first
`ifndef SFA_MAP_SVH
`define SFA_MAP_SVH

// ==========================================================
// Array geometry
`define SFA_ADDR_BITS 24
`define SFA_PAGE_BYTES 264
`define SFA_PAGE_BYTES_LARGE 528
`define SFA_NUM_PAGES 512
`define SFA_SECTOR_PAGES 128
`define SFA_SECTOR_PAGES_STD 256
`define SFA_BLOCK_PAGES 8
`define SFA_SUB0A_PAGES 8

// ==========================================================
// Status and identification
`define SFA_DENS_SMALL 4'h3
`define SFA_DENS_BIG 4'h5
`define SFA_ST_READY_BIT 7
`define SFA_ST_DENS_LSB 2
`define SFA_ST_PROT_BIT 1
`define SFA_ST_P2_BIT 0
`define SFA_ERASED 8'hff
`define SFA_ID_LAST 3'h4

// ==========================================================
// Command codes
`define SFA_CMD_READ 8'h03
`define SFA_CMD_FAST 8'h0b
`define SFA_CMD_STATUS 8'hd7
`define SFA_CMD_INFO 8'h9f
`define SFA_CMD_BWR1 8'h84
`define SFA_CMD_BWR2 8'h87
`define SFA_CMD_PGM1 8'h83
`define SFA_CMD_PGM2 8'h86
`define SFA_CMD_PNE1 8'h88
`define SFA_CMD_PNE2 8'h89
`define SFA_CMD_XFR1 8'h53
`define SFA_CMD_XFR2 8'h55
`define SFA_CMD_PGER 8'h81
`define SFA_CMD_BLKER 8'h50
`define SFA_CMD_SECER 8'h7c

`endif

//--- sfa_pkg.sv
// Types shared by the serial flash array modules.
// Assumes sfa_map.svh is on the include path.
`default_nettype none
package sfa_pkg;
  // ==========================================================
  // Command sequencer and background engine
  typedef enum logic [4:0] {
    ST_CMD = 5'b00001,
    ST_ADDR = 5'b00010,
    ST_DUMMY = 5'b00100,
    ST_DATA = 5'b01000,
    ST_IGN = 5'b10000
  } sfa_state_t;

  typedef enum logic [3:0] {
    OP_NONE = 4'b0001,
    OP_ERASE = 4'b0010,
    OP_PROG = 4'b0100,
    OP_XFER = 4'b1000
  } sfa_op_t;
endpackage
`default_nettype wire

//--- sfa_byte_if.sv
// Byte-level handshake between the serial shifter and the command core.
// Assumes both ends run on the same system clock.
`default_nettype none
interface sfa_byte_if;
  logic rx_valid;
  logic [7:0] rx_byte;
  logic [7:0] tx_byte;
  logic sel;
  logic cs_end;

  modport shifter (output rx_valid, output rx_byte, output sel, output cs_end, input tx_byte);
  modport core (input rx_valid, input rx_byte, input sel, input cs_end, output tx_byte);
endinterface
`default_nettype wire

//--- sfa_spi_shift.sv
// Serial shifter: synchronises the link pins and moves whole bytes.
// Assumes the link clock is at least eight system clocks per period.
`default_nettype none
module sfa_spi_shift
  import sfa_pkg::*;
(
  // System
  input wire logic clock_i,
  input wire logic nrst_i,
  // Link pins
  input wire logic spi_clk_i,
  input wire logic spi_csn_i,
  input wire logic spi_mosi_i,
  output logic spi_miso_o,
  // Byte side
  sfa_byte_if.shifter bif
);
  typedef struct packed {
    logic [1:0] sck_s;
    logic [1:0] csn_s;
    logic [1:0] mosi_s;
    logic sck_prev;
    logic csn_prev;
    logic [2:0] bit_cnt;
    logic have_byte;
    logic [7:0] rx_sh;
    logic [7:0] tx_sh;
    logic miso;
    logic rx_valid;
    logic [7:0] rx_byte;
    logic cs_end;
  } sfa_shift_st_t;

  sfa_shift_st_t q, d;
  logic sel, rise, fall;

  // ==========================================================
  // Edge finding on the synchronised link clock
  assign sel = ~q.csn_s[1];
  assign rise = q.sck_s[1] & ~q.sck_prev;
  assign fall = ~q.sck_s[1] & q.sck_prev;

  always_comb begin
    d = q;
    d.sck_s = {q.sck_s[0], spi_clk_i};
    d.csn_s = {q.csn_s[0], spi_csn_i};
    d.mosi_s = {q.mosi_s[0], spi_mosi_i};
    d.sck_prev = q.sck_s[1];
    d.csn_prev = q.csn_s[1];
    d.rx_valid = 1'b0;
    d.cs_end = q.csn_s[1] & ~q.csn_prev;
    if (!sel) begin
      // Deselected: line idles high, any partial byte is dropped
      d.bit_cnt = 3'h0;
      d.have_byte = 1'b0;
      d.miso = 1'b1;
    end else begin
      if (rise) begin
        d.rx_sh = {q.rx_sh[6:0], q.mosi_s[1]};
        d.bit_cnt = q.bit_cnt + 3'h1;
        if (q.bit_cnt == 3'h7) begin
          d.rx_valid = 1'b1;
          d.rx_byte = {q.rx_sh[6:0], q.mosi_s[1]};
          d.have_byte = 1'b1;
        end
      end
      if (fall) begin
        if (q.bit_cnt == 3'h0) begin
          // Core has had four system clocks to present the next byte
          // No answer before the command byte is in: keep the line high
          d.miso = q.have_byte ? bif.tx_byte[7] : 1'b1;
          d.tx_sh = q.have_byte ? {bif.tx_byte[6:0], 1'b1} : 8'hff;
        end else begin
          d.miso = q.tx_sh[7];
          d.tx_sh = {q.tx_sh[6:0], 1'b1};
        end
      end
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q <= '{sck_s: 2'h3, csn_s: 2'h3, mosi_s: 2'h0, sck_prev: 1'b1, csn_prev: 1'b1,
             bit_cnt: 3'h0, have_byte: 1'b0, rx_sh: 8'h00, tx_sh: 8'hff, miso: 1'b1,
             rx_valid: 1'b0, rx_byte: 8'h00, cs_end: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign spi_miso_o = q.miso;
  assign bif.rx_valid = q.rx_valid;
  assign bif.rx_byte = q.rx_byte;
  assign bif.sel = sel;
  assign bif.cs_end = q.cs_end;
endmodule // sfa_spi_shift
`default_nettype wire

//--- sfa_flash_top_properties.sv
// Checker for the flash array top: link framing and engine busy timing.
// Assumes a mode 3 master on the link pins and the top's own parameters.
`default_nettype none
module sfa_flash_top_properties #(
  parameter int PAGE_BYTES = 264,
  parameter int NUM_PAGES = 512,
  parameter int SECTOR_PAGES = 128
) (
  // System
  input wire logic clock_i,
  input wire logic nrst_i,
  // Link pins
  input wire logic spi_clk_i,
  input wire logic spi_csn_i,
  input wire logic spi_mosi_i,
  input wire logic spi_miso_o,
  // Controls and status
  input wire logic pow2_mode_i,
  input wire logic [NUM_PAGES/SECTOR_PAGES:0] sector_protect_i,
  input wire logic [NUM_PAGES/SECTOR_PAGES:0] sector_lock_i,
  input wire logic busy_o
);
  // Longest engine run is a whole aligned sector, plus slack
  localparam int MAX_BUSY = SECTOR_PAGES * PAGE_BYTES + 8;
  // ==========================================================
  // Helper counters
  logic clk_q;
  logic csn_q;
  logic [11:0] bits_q;
  logic [11:0] last_bits_q;
  logic [3:0] fall_age_q;
  logic [3:0] csn_age_q;
  logic [15:0] busy_len_q;
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      clk_q <= 1'b1;
      csn_q <= 1'b1;
      bits_q <= 12'h000;
      last_bits_q <= 12'h000;
      fall_age_q <= 4'h0;
      csn_age_q <= 4'h0;
      busy_len_q <= 16'h0000;
    end else begin
      clk_q <= spi_clk_i;
      csn_q <= spi_csn_i;
      bits_q <= spi_csn_i ? 12'h000 : bits_q + {11'h000, spi_clk_i & ~clk_q};
      last_bits_q <= (spi_csn_i && !csn_q) ? bits_q : last_bits_q;
      fall_age_q <= (!spi_clk_i && clk_q) ? 4'h0 : fall_age_q + {3'h0, fall_age_q != 4'hf};
      csn_age_q <= (spi_csn_i != csn_q) ? 4'h0 : csn_age_q + {3'h0, csn_age_q != 4'hf};
      busy_len_q <= busy_o ? busy_len_q + 16'h0001 : 16'h0000;
    end
  end
  // ==========================================================
  // Assertions
  chk_miso_deselect: assert property (@(posedge clock_i) disable iff (!nrst_i)
    spi_csn_i [*5] |-> spi_miso_o) else $error("miso low while deselected");
  chk_miso_cmd_high: assert property (@(posedge clock_i) disable iff (!nrst_i)
    !spi_csn_i && bits_q < 12'h008 |-> spi_miso_o) else $error("miso low in command byte");
  chk_miso_stands: assert property (@(posedge clock_i) disable iff (!nrst_i)
    $changed(spi_miso_o) |-> fall_age_q <= 4'h5 || csn_age_q <= 4'h5)
    else $error("miso moved away from a falling link edge");
  chk_busy_after_csn: assert property (@(posedge clock_i) disable iff (!nrst_i)
    $rose(busy_o) |-> spi_csn_i && $past(spi_csn_i, 2)) else $error("busy rose while selected");
  chk_busy_full_addr: assert property (@(posedge clock_i) disable iff (!nrst_i)
    $rose(busy_o) |-> last_bits_q >= 12'h020) else $error("busy after short frame");
  chk_busy_min_len: assert property (@(posedge clock_i) disable iff (!nrst_i)
    $fell(busy_o) |-> busy_len_q >= 16'(PAGE_BYTES - 2)) else $error("engine run below a page");
  chk_busy_max_len: assert property (@(posedge clock_i) disable iff (!nrst_i)
    busy_o |-> busy_len_q <= 16'(MAX_BUSY)) else $error("engine run above a sector");
  chk_protect_all: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (&sector_protect_i) |-> !$rose(busy_o)) else $error("engine ran on protected array");
  chk_lock_all: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (&sector_lock_i) |-> !$rose(busy_o)) else $error("engine ran on locked array");
endmodule // sfa_flash_top_properties
`default_nettype wire

//--- sfa_spi_master_model.sv
// Link master model: mode 3 frames, clock still and high between frames.
// Assumes the bench calls frame one at a time.
`default_nettype none
module sfa_spi_master_model (
  // Link pins
  output logic spi_clk_o,
  output logic spi_csn_o,
  output logic spi_mosi_o,
  input wire logic spi_miso_i,
  // Read bytes
  output logic [7:0] rd_byte_o,
  output logic [15:0] rd_cnt_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    spi_clk_o = 1'b1;
    spi_csn_o = 1'b1;
    spi_mosi_o = 1'b0;
    rd_byte_o = 8'h00;
    rd_cnt_o = 16'h0000;
  end
  // ==========================================================
  // Select with clock high, shift on falling, sample on rising
  task automatic frame(input logic [7:0] tx [$], input int nrd);
    logic [7:0] rx;
    int i;
    int k;
    rx = 8'h00;
    spi_csn_o = 1'b0;
    #160ns;
    for (i = 0; i < tx.size() + nrd; i++) begin
      for (k = 7; k >= 0; k--) begin
        spi_clk_o = 1'b0;
        // Unused bits toggle so a stale level never passes for data
        spi_mosi_o = (i < tx.size()) ? tx[i][k] : ~spi_mosi_o;
        #160ns;
        spi_clk_o = 1'b1;
        rx = {rx[6:0], spi_miso_i};
        #160ns;
      end
      if (i >= tx.size()) begin
        rd_byte_o = rx;
        rd_cnt_o = rd_cnt_o + 16'h0001;
      end
    end
    spi_csn_o = 1'b1;
    spi_mosi_o = ~spi_mosi_o;
    #160ns;
  endtask
endmodule // sfa_spi_master_model
`default_nettype wire

//--- flash_array_organization_test.sv
// Self-checking bench for the flash array top on a small array.
// Assumes the master model and the checker compile first.
`default_nettype none
module flash_array_organization_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef logic [7:0] sfa_tb_bytes_t [$];
  logic clock_i = 1'b0;
  logic nrst_i = 1'b0;
  logic pow2_mode_i = 1'b0;
  logic [2:0] sector_protect_i = 3'h0;
  logic [2:0] sector_lock_i = 3'h0;
  logic spi_clk;
  logic spi_csn;
  logic spi_mosi;
  logic spi_miso;
  logic busy;
  logic [7:0] rd_byte;
  logic [15:0] rd_cnt;
  logic [7:0] exp_q [$];
  logic [7:0] d [6];
  logic [23:0] junk;
  int pgs [4] = '{31, 3, 9, 23};
  int n_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  always #20ns clock_i = ~clock_i;
  // Small array keeps erase runs short: 32 pages, 16 per sector
  sfa_flash_top #(.PAGE_BYTES(264), .NUM_PAGES(32), .SECTOR_PAGES(16)) u_dut (
    .clock_i(clock_i), .nrst_i(nrst_i), .spi_clk_i(spi_clk), .spi_csn_i(spi_csn),
    .spi_mosi_i(spi_mosi), .spi_miso_o(spi_miso), .pow2_mode_i(pow2_mode_i),
    .sector_protect_i(sector_protect_i), .sector_lock_i(sector_lock_i), .busy_o(busy));
  sfa_spi_master_model u_master (.spi_clk_o(spi_clk), .spi_csn_o(spi_csn),
    .spi_mosi_o(spi_mosi), .spi_miso_i(spi_miso), .rd_byte_o(rd_byte), .rd_cnt_o(rd_cnt));
  // ==========================================================
  // Checks and report
  task automatic compare_byte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic compare_flag(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("checked %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  always @(rd_cnt) begin
    if (rd_cnt !== 16'h0000) begin
      compare_byte(rd_byte, (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx);
    end
  end
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 60000) begin
      n_errors++;
      close_out();
    end
  end
  // ==========================================================
  // Stimulus helpers
  // Bits above the page field carry noise that the decoder must drop
  function automatic logic [23:0] adr(input int pg, input int by, input logic p2);
    return p2 ? {junk[23:13], pg[4:0], by[7:0]} : {junk[23:14], pg[4:0], by[8:0]};
  endfunction
  function automatic sfa_tb_bytes_t cmd(input logic [7:0] c, input logic [23:0] a);
    return {c, a[23:16], a[15:8], a[7:0]};
  endfunction
  task automatic set_in(input logic [2:0] p, input logic [2:0] l, input logic m);
    @(posedge clock_i);
    #2ns;
    sector_protect_i = p;
    sector_lock_i = l;
    pow2_mode_i = m;
  endtask
  task automatic read(input sfa_tb_bytes_t tx, input sfa_tb_bytes_t ex);
    foreach (ex[i]) exp_q.push_back(ex[i]);
    @(posedge clock_i);
    #2ns;
    u_master.frame(tx, ex.size());
  endtask
  task automatic op(input sfa_tb_bytes_t tx, input logic want);
    logic seen;
    int i;
    seen = 1'b0;
    @(posedge clock_i);
    #2ns;
    u_master.frame(tx, 0);
    for (i = 0; i < 20; i++) begin
      @(posedge clock_i);
      #2ns;
      seen = seen | (busy === 1'b1);
    end
    compare_flag(seen, want);
    for (i = 0; i < 6000 && busy !== 1'b0; i++) @(posedge clock_i);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(32'h6bc6));
    junk = 24'($urandom());
    foreach (d[i]) d[i] = 8'($urandom());
    repeat (5) @(posedge clock_i);
    #2ns;
    nrst_i = 1'b1;
    read({8'hd7}, {8'h8c, 8'h8c});
    read({8'h9f}, {8'h5a, 8'h3c, 8'h00, 8'h00, 8'hff, 8'hff});
    set_in(3'h1, 3'h0, 1'b1);
    read({8'hd7}, {8'h8f});
    set_in(3'h0, 3'h0, 1'b0);
    op({cmd(8'h84, adr(0, 261, 1'b0)), d[0], d[1], d[2], d[3], d[4], d[5]}, 1'b0);
    foreach (pgs[i]) op(cmd(8'h83, adr(pgs[i], 0, 1'b0)), 1'b1);
    read(cmd(8'h03, adr(31, 261, 1'b0)), {d[0], d[1], d[2], 8'hff, 8'hff, 8'hff});
    read({cmd(8'h0b, adr(3, 0, 1'b0)), 8'h00}, {d[3], d[4], d[5]});
    op(cmd(8'h86, adr(20, 0, 1'b0)), 1'b0);
    set_in(3'h7, 3'h0, 1'b0);
    op(cmd(8'h81, adr(3, 0, 1'b0)), 1'b0);
    set_in(3'h0, 3'h7, 1'b0);
    op(cmd(8'h7c, adr(31, 0, 1'b0)), 1'b0);
    set_in(3'h1, 3'h0, 1'b0);
    op(cmd(8'h7c, adr(3, 0, 1'b0)), 1'b0);
    op(cmd(8'h7c, adr(9, 0, 1'b0)), 1'b1);
    set_in(3'h0, 3'h0, 1'b0);
    op(cmd(8'h50, adr(25, 0, 1'b0)), 1'b1);
    read(cmd(8'h03, adr(3, 0, 1'b0)), {d[3]});
    read(cmd(8'h03, adr(9, 0, 1'b0)), {8'hff});
    read(cmd(8'h03, adr(31, 262, 1'b0)), {8'hff});
    read(cmd(8'h03, adr(23, 0, 1'b0)), {d[3]});
    op(cmd(8'h7c, adr(20, 0, 1'b0)), 1'b1);
    read(cmd(8'h03, adr(23, 0, 1'b0)), {8'hff});
    set_in(3'h0, 3'h0, 1'b1);
    read(cmd(8'h03, adr(3, 0, 1'b1)), {d[3]});
    repeat (4) @(posedge clock_i);
    compare_flag(exp_q.size() == 0, 1'b1);
    close_out();
  end
endmodule // flash_array_organization_test
bind sfa_flash_top sfa_flash_top_properties #(
  .PAGE_BYTES(PAGE_BYTES), .NUM_PAGES(NUM_PAGES), .SECTOR_PAGES(SECTOR_PAGES)
) u_props (.clock_i(clock_i), .nrst_i(nrst_i), .spi_clk_i(spi_clk_i),
  .spi_csn_i(spi_csn_i), .spi_mosi_i(spi_mosi_i), .spi_miso_o(spi_miso_o),
  .pow2_mode_i(pow2_mode_i), .sector_protect_i(sector_protect_i),
  .sector_lock_i(sector_lock_i), .busy_o(busy_o));
`default_nettype wire
